// [hdl/ofd_defs.svh]
`ifndef OFD_DEFS_SVH
`define OFD_DEFS_SVH
// ==========================================
// Register offsets and fields
`define OFD_ADDR_CTRL 4'h0
`define OFD_ADDR_STATUS 4'h4
`define OFD_ADDR_LAST 4'h8
`define OFD_CTRL_ENABLE_BIT 0
`define OFD_CTRL_RESET 1'h1
`define OFD_STATUS_ILLEGAL_BIT 16
`define OFD_LAST_CONDITION_CODE_LSB 16
// ==========================================
// Bit operation codes
`define OFD_BOP_SET 3'h0
`define OFD_BOP_CLEAR 3'h1
`define OFD_BOP_TOGGLE 3'h2
`define OFD_BOP_TEST 3'h4
`define OFD_BOP_XOR 3'h5
// ==========================================
// Register numbering and immediate split
`define OFD_AGEN1_BANK 1'h0
`define OFD_AGEN2_BANK 1'h1
`define OFD_SHIFT_LSB 0
`define OFD_LEN_LSB 6
`define OFD_FIELD6_W 6
`endif

// [hdl/ofd_pkg.sv]
`include "ofd_defs.svh"
package ofd_pkg;
   // ==========================================
   // Bit operation kinds
   typedef enum logic [2:0] {
      OFD_OP_SET = `OFD_BOP_SET,
      OFD_OP_CLEAR = `OFD_BOP_CLEAR,
      OFD_OP_TOGGLE = `OFD_BOP_TOGGLE,
      OFD_OP_TEST = `OFD_BOP_TEST,
      OFD_OP_XOR = `OFD_BOP_XOR
   } ofd_bop_type;
   // ==========================================
   // Raw instruction fields
   typedef struct packed {
      logic loop_abort;
      logic branch_type;
      logic [2:0] bit_op_select;
      logic [3:0] data_reg_select;
      logic [3:0] complementary_reg_select;
      logic [4:0] condition_code;
      logic clear_current_irq;
      logic [7:0] immediate_data;
      logic [3:0] immediate_extension;
      logic [2:0] agen1_index_select;
      logic [2:0] agen1_modify_select;
      logic [2:0] agen2_index_select;
      logic [2:0] agen2_modify_select;
      logic agen1_direction;
      logic agen_select;
      logic else_clause;
      logic cache_flush_bit;
      logic emulation_halt_select;
   } ofd_fields_type;
   // ==========================================
   // Decoded control
   typedef struct packed {
      logic pop_loop_stack;
      logic pop_pc_stack;
      logic is_call;
      ofd_bop_type bit_op;
      logic bit_op_legal;
      logic [3:0] data_reg;
      logic [3:0] comp_reg;
      logic [4:0] condition_code_code;
      logic [31:0] condition_code_select;
      logic clear_irq;
      logic [11:0] imm12;
      logic [5:0] shift_amount;
      logic [5:0] field_length;
      logic [3:0] agen1_index;
      logic [3:0] agen1_modify;
      logic [3:0] agen2_index;
      logic [3:0] agen2_modify;
      logic mem_write;
      logic use_agen2;
      logic has_else;
      logic flush_cache;
      logic emu_halt;
      logic idle_halt;
   } ofd_ctrl_type;
endpackage

// [hdl/ofd_decoder.sv]
// The register offsets and the Avalon-MM register port were decided locally.
`include "ofd_defs.svh"
// Overview of operation
// - Loop abort 1 pops loop and PC stacks on taken branch; 0 leaves them.
// - Bit op select: 000 set, 001 clear, 010 toggle, 100 test, 101 xor.
// - Data and complementary register fields each pick register 0 to 15.
// - Five-bit condition code 0 to 31 selects one governing condition.
// - Clear-interrupt bit 1 clears current interrupt; 0 leaves it active.
// - Immediate extension gives four upper bits above data, making 12 bits.
// - Low six immediate bits are shift amount, high six are field length.
// - First address generator index field picks index register 0 to 7.
// - First address generator modify field picks modify register 0 to 7.
// - Second address generator index and modify fields pick registers 8 to 15.
module ofd_decoder
   import ofd_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic CE,
   input wire logic FIELD_VALID,
   input wire ofd_fields_type FIELDS,
   input wire logic BRANCH_TAKEN,
   output logic DECODE_VALID,
   output ofd_ctrl_type CTRL,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST
);
   // ==========================================
   // Decode state
   logic accept;
   logic decode_enable;
   ofd_ctrl_type next_ctrl;
   logic next_decode_valid;
   logic [11:0] imm;

   assign accept = CE & FIELD_VALID & decode_enable;
   assign imm = {FIELDS.immediate_extension, FIELDS.immediate_data};

   always_comb begin
      next_ctrl = CTRL;
      next_decode_valid = DECODE_VALID;
      if (CE) begin
         next_decode_valid = accept;
      end
      if (accept) begin
         next_ctrl.pop_loop_stack = FIELDS.loop_abort & BRANCH_TAKEN;
         next_ctrl.pop_pc_stack = FIELDS.loop_abort & BRANCH_TAKEN;
         next_ctrl.bit_op_legal = 1'h1;
         unique case (FIELDS.bit_op_select)
            `OFD_BOP_SET: next_ctrl.bit_op = OFD_OP_SET;
            `OFD_BOP_CLEAR: next_ctrl.bit_op = OFD_OP_CLEAR;
            `OFD_BOP_TOGGLE: next_ctrl.bit_op = OFD_OP_TOGGLE;
            `OFD_BOP_TEST: next_ctrl.bit_op = OFD_OP_TEST;
            `OFD_BOP_XOR: next_ctrl.bit_op = OFD_OP_XOR;
            default: begin
               next_ctrl.bit_op = OFD_OP_SET;
               next_ctrl.bit_op_legal = 1'h0;
            end
         endcase
         next_ctrl.data_reg = FIELDS.data_reg_select;
         next_ctrl.comp_reg = FIELDS.complementary_reg_select;
         next_ctrl.condition_code_code = FIELDS.condition_code;
         next_ctrl.condition_code_select = 32'h00000001 << FIELDS.condition_code;
         next_ctrl.clear_irq = FIELDS.clear_current_irq;
         next_ctrl.imm12 = imm;
         next_ctrl.shift_amount = imm[`OFD_SHIFT_LSB +: `OFD_FIELD6_W];
         next_ctrl.field_length = imm[`OFD_LEN_LSB +: `OFD_FIELD6_W];
         next_ctrl.agen1_index = {`OFD_AGEN1_BANK, FIELDS.agen1_index_select};
         next_ctrl.agen1_modify = {`OFD_AGEN1_BANK, FIELDS.agen1_modify_select};
         next_ctrl.agen2_index = {`OFD_AGEN2_BANK, FIELDS.agen2_index_select};
         next_ctrl.agen2_modify = {`OFD_AGEN2_BANK, FIELDS.agen2_modify_select};
         next_ctrl.is_call = FIELDS.branch_type;
         next_ctrl.mem_write = FIELDS.agen1_direction;
         next_ctrl.use_agen2 = FIELDS.agen_select;
         next_ctrl.has_else = FIELDS.else_clause;
         next_ctrl.flush_cache = FIELDS.cache_flush_bit;
         next_ctrl.emu_halt = ~FIELDS.emulation_halt_select;
         next_ctrl.idle_halt = FIELDS.emulation_halt_select;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         CTRL <= '0;
         DECODE_VALID <= 1'h0;
      end else begin
         CTRL <= next_ctrl;
         DECODE_VALID <= next_decode_valid;
      end
   end

   // ==========================================
   // Avalon-MM slave
   logic ack;
   logic next_ack;
   logic [31:0] next_readdata;
   logic next_decode_enable;
   logic illegal_seen;
   logic next_illegal_seen;
   logic [15:0] decode_count;
   logic [15:0] next_decode_count;
   logic bus_req;
   logic wr_take;

   assign bus_req = AVS_READ | AVS_WRITE;
   // Clock enable low stretches the wait
   assign AVS_WAITREQUEST = bus_req & ~(ack & CE);
   assign wr_take = CE & AVS_WRITE & ack;

   always_comb begin
      next_ack = ack;
      next_readdata = AVS_READDATA;
      next_decode_enable = decode_enable;
      next_illegal_seen = illegal_seen;
      next_decode_count = decode_count;
      if (CE) begin
         next_ack = bus_req & ~ack;
         if (AVS_READ & ~ack) begin
            unique case (AVS_ADDRESS)
               `OFD_ADDR_CTRL: next_readdata = {31'h00000000, decode_enable};
               `OFD_ADDR_STATUS: next_readdata = {15'h0000, illegal_seen, decode_count};
               `OFD_ADDR_LAST: next_readdata = {11'h000, CTRL.condition_code_code, 4'h0, CTRL.imm12};
               default: next_readdata = 32'h00000000;
            endcase
         end
         if (wr_take && AVS_ADDRESS == `OFD_ADDR_CTRL && AVS_BYTEENABLE[0]) begin
            next_decode_enable = AVS_WRITEDATA[`OFD_CTRL_ENABLE_BIT];
         end
         if (wr_take && AVS_ADDRESS == `OFD_ADDR_STATUS && AVS_BYTEENABLE[2]
             && AVS_WRITEDATA[`OFD_STATUS_ILLEGAL_BIT]) begin
            next_illegal_seen = 1'h0;
         end
         // Set wins over clear
         if (accept && next_ctrl.bit_op_legal == 1'h0) begin
            next_illegal_seen = 1'h1;
         end
         if (accept) begin
            next_decode_count = decode_count + 16'h0001;
         end
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ack <= 1'h0;
         AVS_READDATA <= 32'h00000000;
         decode_enable <= `OFD_CTRL_RESET;
         illegal_seen <= 1'h0;
         decode_count <= 16'h0000;
      end else begin
         ack <= next_ack;
         AVS_READDATA <= next_readdata;
         decode_enable <= next_decode_enable;
         illegal_seen <= next_illegal_seen;
         decode_count <= next_decode_count;
      end
   end

   // ==========================================
   // Assertions
   AST_POP_TAKEN: assert property (@(posedge CLK) disable iff (!NRST)
      accept && FIELDS.loop_abort && BRANCH_TAKEN |=> CTRL.pop_loop_stack && CTRL.pop_pc_stack)
      else $error("Stacks not popped on taken abort branch");

   AST_POP_QUIET: assert property (@(posedge CLK) disable iff (!NRST)
      accept && !(FIELDS.loop_abort && BRANCH_TAKEN) |=> !CTRL.pop_loop_stack && !CTRL.pop_pc_stack)
      else $error("Stacks popped without taken abort branch");

   AST_BOP_TEST: assert property (@(posedge CLK) disable iff (!NRST)
      accept && FIELDS.bit_op_select == 3'h4 |=> CTRL.bit_op == OFD_OP_TEST && CTRL.bit_op_legal)
      else $error("Test code not decoded");

   AST_BOP_BAD: assert property (@(posedge CLK) disable iff (!NRST)
      accept && FIELDS.bit_op_select inside {3'h3, 3'h6, 3'h7} |=> !CTRL.bit_op_legal && illegal_seen)
      else $error("Illegal bit op accepted");

   AST_REGS: assert property (@(posedge CLK) disable iff (!NRST)
      accept |=> CTRL.data_reg == $past(FIELDS.data_reg_select)
         && CTRL.comp_reg == $past(FIELDS.complementary_reg_select))
      else $error("Register select mismatch");

   AST_CONDITION_CODE: assert property (@(posedge CLK) disable iff (!NRST)
      DECODE_VALID |-> CTRL.condition_code_select == (32'h00000001 << CTRL.condition_code_code) && $onehot(CTRL.condition_code_select))
      else $error("Condition select not one-hot of code");

   AST_CLR_IRQ: assert property (@(posedge CLK) disable iff (!NRST)
      accept |=> CTRL.clear_irq == $past(FIELDS.clear_current_irq))
      else $error("Clear interrupt mismatch");

   AST_IMM: assert property (@(posedge CLK) disable iff (!NRST)
      accept |=> CTRL.imm12 == {$past(FIELDS.immediate_extension), $past(FIELDS.immediate_data)})
      else $error("Immediate extension misplaced");

   AST_SHIFT_LEN: assert property (@(posedge CLK) disable iff (!NRST)
      DECODE_VALID |-> CTRL.shift_amount == CTRL.imm12[5:0] && CTRL.field_length == CTRL.imm12[11:6])
      else $error("Shift or length split wrong");

   AST_AGEN1_IDX: assert property (@(posedge CLK) disable iff (!NRST)
      accept |=> CTRL.agen1_index < 4'h8 && CTRL.agen1_index[2:0] == $past(FIELDS.agen1_index_select))
      else $error("First index out of 0 to 7");

   AST_AGEN1_MOD: assert property (@(posedge CLK) disable iff (!NRST)
      accept |=> CTRL.agen1_modify < 4'h8 && CTRL.agen1_modify[2:0] == $past(FIELDS.agen1_modify_select))
      else $error("First modify out of 0 to 7");

   AST_AGEN2: assert property (@(posedge CLK) disable iff (!NRST)
      accept |=> CTRL.agen2_index >= 4'h8 && CTRL.agen2_modify >= 4'h8
         && CTRL.agen2_index[2:0] == $past(FIELDS.agen2_index_select)
         && CTRL.agen2_modify[2:0] == $past(FIELDS.agen2_modify_select))
      else $error("Second bank out of 8 to 15");

   AST_BITS: assert property (@(posedge CLK) disable iff (!NRST)
      accept |=> CTRL.is_call == $past(FIELDS.branch_type) && CTRL.mem_write == $past(FIELDS.agen1_direction)
         && CTRL.use_agen2 == $past(FIELDS.agen_select) && CTRL.has_else == $past(FIELDS.else_clause)
         && CTRL.flush_cache == $past(FIELDS.cache_flush_bit))
      else $error("Single-bit field mismatch");

   AST_BUS_ANSWER: assert property (@(posedge CLK) disable iff (!NRST)
      CE && bus_req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST || !bus_req || !CE)
      else $error("Bus answer late");

   AST_DISABLED: assert property (@(posedge CLK) disable iff (!NRST)
      CE && !decode_enable |=> !DECODE_VALID)
      else $error("Decode while disabled");

   AST_BOP_SET: assert property (@(posedge CLK) disable iff (!NRST)
      accept && FIELDS.bit_op_select == 3'h0 |=> CTRL.bit_op == OFD_OP_SET && CTRL.bit_op_legal)
      else $error("Set code not decoded");

   AST_BOP_CLEAR: assert property (@(posedge CLK) disable iff (!NRST)
      accept && FIELDS.bit_op_select == 3'h1 |=> CTRL.bit_op == OFD_OP_CLEAR && CTRL.bit_op_legal)
      else $error("Clear code not decoded");

   AST_BOP_TOGGLE: assert property (@(posedge CLK) disable iff (!NRST)
      accept && FIELDS.bit_op_select == 3'h2 |=> CTRL.bit_op == OFD_OP_TOGGLE && CTRL.bit_op_legal)
      else $error("Toggle code not decoded");

   AST_BOP_XOR: assert property (@(posedge CLK) disable iff (!NRST)
      accept && FIELDS.bit_op_select == 3'h5 |=> CTRL.bit_op == OFD_OP_XOR && CTRL.bit_op_legal)
      else $error("Xor code not decoded");

   AST_CONDITION_CODE_CODE: assert property (@(posedge CLK) disable iff (!NRST)
      accept |=> CTRL.condition_code_code == $past(FIELDS.condition_code) && CTRL.condition_code_select[CTRL.condition_code_code])
      else $error("Condition code not carried");

   AST_SHIFT_SRC: assert property (@(posedge CLK) disable iff (!NRST)
      accept |=> CTRL.shift_amount == $past(FIELDS.immediate_data[5:0])
         && CTRL.field_length == {$past(FIELDS.immediate_extension), $past(FIELDS.immediate_data[7:6])})
      else $error("Shift or length not from immediate");

   AST_HALT: assert property (@(posedge CLK) disable iff (!NRST)
      accept |=> CTRL.emu_halt == !$past(FIELDS.emulation_halt_select)
         && CTRL.idle_halt == $past(FIELDS.emulation_halt_select))
      else $error("Halt select mismatch");

   AST_CTRL_HOLD: assert property (@(posedge CLK) disable iff (!NRST)
      !accept |=> CTRL == $past(CTRL))
      else $error("Controls moved without accept");

   AST_VALID_SET: assert property (@(posedge CLK) disable iff (!NRST)
      accept |=> DECODE_VALID)
      else $error("Accepted decode not flagged");

   AST_VALID_PULSE: assert property (@(posedge CLK) disable iff (!NRST)
      CE && !accept |=> !DECODE_VALID)
      else $error("Decode flag without accept");

   AST_CE_FREEZE: assert property (@(posedge CLK) disable iff (!NRST)
      !CE |=> DECODE_VALID == $past(DECODE_VALID) && ack == $past(ack) && decode_count == $past(decode_count)
         && illegal_seen == $past(illegal_seen) && AVS_READDATA == $past(AVS_READDATA))
      else $error("State moved while clock enable low");

   AST_BUS_CE_WAIT: assert property (@(posedge CLK) disable iff (!NRST)
      bus_req && !CE |-> AVS_WAITREQUEST)
      else $error("Bus answered while clock enable low");

   AST_COUNT: assert property (@(posedge CLK) disable iff (!NRST)
      accept |=> decode_count == $past(decode_count) + 16'h0001)
      else $error("Decode count not advanced");

   AST_STICKY: assert property (@(posedge CLK) disable iff (!NRST)
      illegal_seen && !(wr_take && AVS_ADDRESS == `OFD_ADDR_STATUS && AVS_BYTEENABLE[2]
         && AVS_WRITEDATA[`OFD_STATUS_ILLEGAL_BIT]) |=> illegal_seen)
      else $error("Illegal flag lost");

   AST_CTRL_READ: assert property (@(posedge CLK) disable iff (!NRST)
      AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `OFD_ADDR_CTRL
         |-> AVS_READDATA == {31'h00000000, decode_enable})
      else $error("Control read data wrong");

   AST_WR_ENABLE: assert property (@(posedge CLK) disable iff (!NRST)
      wr_take && AVS_ADDRESS == `OFD_ADDR_CTRL && AVS_BYTEENABLE[0]
         |=> decode_enable == $past(AVS_WRITEDATA[`OFD_CTRL_ENABLE_BIT]))
      else $error("Enable write not taken");
endmodule

// [verif/ofd_seq_model.sv]
module ofd_seq_model
   import ofd_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   output logic FIELD_VALID,
   output ofd_fields_type FIELDS,
   output logic BRANCH_TAKEN
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int FW = $bits(ofd_fields_type);
   logic [FW+1:0] q[$];
   logic [FW+1:0] e;
   // ==========================================
   // Queue of fetched words, idle entries included
   task automatic send(input logic v, input ofd_fields_type f, input logic t);
      q.push_back({v, t, f});
   endtask
   // ==========================================
   // One entry per cycle; idle fields keep moving
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         FIELD_VALID <= 1'h0;
         FIELDS <= '0;
         BRANCH_TAKEN <= 1'h0;
      end else begin
         e = '0;
         if (q.size() != 0) begin
            e = q.pop_front();
         end
         FIELD_VALID <= e[FW+1];
         FIELDS <= e[FW+1] ? e[FW-1:0] : ~FIELDS;
         BRANCH_TAKEN <= e[FW+1] ? e[FW] : ~BRANCH_TAKEN;
      end
   end
endmodule

// [verif/opcode_field_decoder_test.sv]
module opcode_field_decoder_test;
   import ofd_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, nrst, ce, fv, bt, dv, rd, wr, wq;
   logic [3:0] adr, be;
   logic [31:0] wd, rdat;
   ofd_fields_type fld, lf;
   ofd_ctrl_type ctrl;
   ofd_ctrl_type exp_q[$];
   int n_fail = 0;
   int num_checks = 0;
   ofd_seq_model seq_u (.CLK(clk), .NRST(nrst), .FIELD_VALID(fv), .FIELDS(fld), .BRANCH_TAKEN(bt));
   ofd_decoder dut_u (.CLK(clk), .NRST(nrst), .CE(ce), .FIELD_VALID(fv), .FIELDS(fld),
      .BRANCH_TAKEN(bt), .DECODE_VALID(dv), .CTRL(ctrl), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wq));
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   // ==========================================
   // Compare, verdict and bus tasks
   task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] ex);
      num_checks++;
      if (seen !== ex) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      rd <= ~w;
      wr <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk);
         n++;
         if (n > 50) begin
            check("bus wait", 1, 0);
            test_done();
         end
      end while (wq !== 1'h0);
      q = rdat;
      rd <= 1'h0;
      wr <= 1'h0;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      bus(1'h0, a, 32'h0, q);
      check(nm, q, e);
   endtask
   // ==========================================
   // Stimulus words and expected decode
   function automatic ofd_fields_type mk(input logic [7:0] k);
      return ofd_fields_type'({6{k * 8'h25}} ^ 48'h0F0F_A5A5_3C3C);
   endfunction
   function automatic ofd_ctrl_type ex(input ofd_fields_type f, input logic t);
      ofd_ctrl_type c;
      logic [11:0] im;
      c = '0;
      im = {f.immediate_extension, f.immediate_data};
      c.pop_loop_stack = f.loop_abort & t;
      c.pop_pc_stack = f.loop_abort & t;
      c.is_call = f.branch_type;
      c.bit_op_legal = f.bit_op_select inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
      c.bit_op = c.bit_op_legal ? ofd_bop_type'(f.bit_op_select) : OFD_OP_SET;
      c.data_reg = f.data_reg_select;
      c.comp_reg = f.complementary_reg_select;
      c.condition_code_code = f.condition_code;
      c.condition_code_select = 32'h1 << f.condition_code;
      c.clear_irq = f.clear_current_irq;
      c.imm12 = im;
      c.shift_amount = im[5:0];
      c.field_length = im[11:6];
      c.agen1_index = {1'h0, f.agen1_index_select};
      c.agen1_modify = {1'h0, f.agen1_modify_select};
      c.agen2_index = {1'h1, f.agen2_index_select};
      c.agen2_modify = {1'h1, f.agen2_modify_select};
      c.mem_write = f.agen1_direction;
      c.use_agen2 = f.agen_select;
      c.has_else = f.else_clause;
      c.flush_cache = f.cache_flush_bit;
      c.emu_halt = ~f.emulation_halt_select;
      c.idle_halt = f.emulation_halt_select;
      return c;
   endfunction
   task automatic go(input logic [7:0] k, input logic acc);
      seq_u.send(1'h1, mk(k), k[0] ^ k[3]);
      if (acc) begin
         exp_q.push_back(ex(mk(k), k[0] ^ k[3]));
      end
   endtask
   task automatic drain;
      int n;
      n = 0;
      while (seq_u.q.size() != 0 || exp_q.size() != 0) begin
         @(negedge clk);
         n++;
         if (n > 100) begin
            check("decode wait", 1, 0);
            test_done();
         end
      end
      repeat (3) @(negedge clk);
   endtask
   // ==========================================
   // Decode monitor
   always @(negedge clk) begin
      if (dv === 1'h1) begin
         if (exp_q.size() == 0) begin
            check("unexpected decode", 1, 0);
         end else begin
            check("ctrl", ctrl, exp_q.pop_front());
         end
      end
   end
   initial begin
      #800000;
      check("run time", 1, 0);
      test_done();
   end
   // ==========================================
   // Main sequence
   initial begin
      logic [31:0] q;
      logic ill;
      ofd_ctrl_type c;
      nrst = 1'h0;
      ce = 1'h1;
      rd = 1'h0;
      wr = 1'h0;
      adr = 4'h0;
      wd = 32'h0;
      be = 4'hF;
      ill = 1'h0;
      repeat (10) @(posedge clk);
      nrst <= 1'h1;
      rdchk(4'h0, 32'h1, "ctrl reset");
      rdchk(4'h4, 32'h0, "status reset");
      rdchk(4'h8, 32'h0, "last reset");
      bus(1'h1, 4'hC, 32'hFFFF_FFFF, q);
      rdchk(4'hC, 32'h0, "unmapped");
      @(negedge clk);
      for (int i = 0; i < 32; i++) begin
         go(i[7:0], 1'h1);
         c = ex(mk(i[7:0]), 1'h0);
         ill = ill | ~c.bit_op_legal;
         if (i % 8 == 7) begin
            seq_u.send(1'h0, '0, 1'h0);
         end
      end
      drain();
      lf = mk(8'h1F);
      rdchk(4'h4, {15'h0, ill, 16'h0020}, "status");
      rdchk(4'h8, {11'h0, lf.condition_code, 4'h0, lf.immediate_extension, lf.immediate_data}, "last");
      be <= 4'hB;
      bus(1'h1, 4'h4, 32'h0001_0000, q);
      rdchk(4'h4, {15'h0, ill, 16'h0020}, "status kept");
      be <= 4'hF;
      bus(1'h1, 4'h4, 32'h0001_0000, q);
      rdchk(4'h4, 32'h0000_0020, "status cleared");
      bus(1'h1, 4'h0, 32'h0, q);
      @(negedge clk);
      go(8'h41, 1'h0);
      drain();
      bus(1'h1, 4'h0, 32'h1, q);
      @(negedge clk);
      go(8'h42, 1'h0);
      @(posedge clk);
      ce <= 1'h0;
      @(posedge clk);
      ce <= 1'h1;
      @(negedge clk);
      go(8'h43, 1'h1);
      drain();
      rdchk(4'h4, 32'h0000_0021, "count after refusals");
      test_done();
   end
endmodule
